// ==== design/sddf_defs.vh ====
`ifndef SDDF_DEFS_VH
`define SDDF_DEFS_VH

// system clock, 200 MHz
`define SDDF_CLK_HZ 29'h0bebc200
// nco accumulator width
`define SDDF_NCO_W 29

// selectable output rate limits in samples per second
`define SDDF_RATE_W 18
`define SDDF_RATE_MAX 18'h30d40
`define SDDF_RATE_EDGE_LO 18'h0c800
`define SDDF_RATE_EDGE_HI 18'h19000

// oversampling band codes
`define SDDF_OSR_256 2'h0
`define SDDF_OSR_128 2'h1
`define SDDF_OSR_64 2'h2

// decimation count limits (ratio minus one)
`define SDDF_DEC_MAX_256 8'hff
`define SDDF_DEC_MAX_128 8'h7f
`define SDDF_DEC_MAX_64 8'h3f

// ratio values as seen on the status output
`define SDDF_RATIO_256 9'h100
`define SDDF_RATIO_128 9'h080
`define SDDF_RATIO_64 9'h040

// log2 of twice the ratio, for the nco increment
`define SDDF_INC_SH_256 5'h09
`define SDDF_INC_SH_128 5'h08
`define SDDF_INC_SH_64 5'h07

// output scaling: filter gain is ratio^5, full scale lands on bit 23
`define SDDF_SHIFT_256 6'h11
`define SDDF_SHIFT_128 6'h0c
`define SDDF_SHIFT_64 6'h07

// sample word
`define SDDF_WORD_W 24
`define SDDF_WORD_MAX 24'h7fffff
`define SDDF_WORD_MIN 24'h800000

// filter order and words thrown away after a restart
`define SDDF_ORDER 5
`define SDDF_SETTLE 3'h5

`endif

// ==== design/sddf_fifo.v ====
module sddf_fifo #(
  parameter WIDTH = 192,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // filling side
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  // draining side
  output reg [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  // the output register refills as soon as it empties or is taken
  assign pop = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // sddf_fifo

// ==== design/sddf_sinc.v ====
`include "sddf_defs.vh"

module sddf_sinc #(
  parameter ORDER = 5,
  parameter W = 42
) (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // control
  input wire clr,
  input wire [1:0] osr_sel,
  // modulator bit stream
  input wire in_en,
  input wire in_bit,
  // decimated output
  input wire dec_en,
  output reg [`SDDF_WORD_W-1:0] out_word,
  output reg out_en
);

  wire [W-1:0] integ [0:ORDER-1];
  wire [W-1:0] dly [0:ORDER-1];
  wire [W-1:0] comb [0:ORDER];
  wire [W-1:0] x;
  reg [5:0] shift;
  wire signed [W-1:0] scaled;

  // one bit maps to +1 or -1
  assign x = {{(W-1){~in_bit}}, 1'b1};
  assign comb[0] = integ[ORDER-1];

  genvar k;
  generate
    for (k = 0; k < ORDER; k = k + 1) begin : g_stage
      // each stage owns its registers so every array element has one driver
      reg [W-1:0] integ_q;
      reg [W-1:0] dly_q;
      assign integ[k] = integ_q;
      assign dly[k] = dly_q;
      // integrators may wrap: the combs undo it exactly while W covers the gain
      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          integ_q <= {W{1'b0}};
          dly_q <= {W{1'b0}};
        end else if (clr) begin
          integ_q <= {W{1'b0}};
          dly_q <= {W{1'b0}};
        end else begin
          if (in_en) begin
            integ_q <= integ_q + ((k == 0) ? x : integ[(k == 0) ? 0 : k-1]);
          end
          if (dec_en) begin
            dly_q <= comb[k];
          end
        end
      end
      // symmetric impulse response gives linear phase
      assign comb[k+1] = comb[k] - dly[k];
    end
  endgenerate

  always @* begin
    shift = `SDDF_SHIFT_256;
    if (osr_sel == `SDDF_OSR_128) begin
      shift = `SDDF_SHIFT_128;
    end else if (osr_sel == `SDDF_OSR_64) begin
      shift = `SDDF_SHIFT_64;
    end
  end

  assign scaled = $signed(comb[ORDER]) >>> shift;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      out_word <= {`SDDF_WORD_W{1'b0}};
      out_en <= 1'b0;
    end else begin
      out_en <= dec_en && !clr;
      if (dec_en) begin
        // clamp to the nearest code instead of wrapping
        if (scaled > $signed({{(W-`SDDF_WORD_W){1'b0}}, `SDDF_WORD_MAX})) begin
          out_word <= `SDDF_WORD_MAX;
        end else if (scaled < $signed({{(W-`SDDF_WORD_W){1'b1}}, `SDDF_WORD_MIN})) begin
          out_word <= `SDDF_WORD_MIN;
        end else begin
          out_word <= scaled[`SDDF_WORD_W-1:0];
        end
      end
    end
  end

endmodule // sddf_sinc

// ==== design/sddf_top.v ====
`include "sddf_defs.vh"

module sddf_top #(
  parameter CHANNELS = 8,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // rate selection, samples per second
  input wire [`SDDF_RATE_W-1:0] rate_req,
  // modulator side
  output reg mod_clk,
  input wire [CHANNELS-1:0] mod_bits,
  // sample stream
  output wire [CHANNELS*`SDDF_WORD_W-1:0] smp_data,
  output wire smp_valid,
  input wire smp_ready,
  // status
  output reg frame_strobe,
  output reg overrun,
  output reg [8:0] osr_active
);

  localparam ST_IDLE = 3'b001;
  localparam ST_SETTLE = 3'b010;
  localparam ST_RUN = 3'b100;
  localparam DW = CHANNELS * `SDDF_WORD_W;

  reg [2:0] state;
  reg [`SDDF_RATE_W-1:0] rate_cur;
  reg [1:0] osr_sel;
  reg [`SDDF_NCO_W-1:0] acc;
  reg mod_tick;
  reg [7:0] dec_cnt;
  reg dec_tick;
  reg [2:0] settle_cnt;
  reg flt_clr;
  reg [DW-1:0] pend_data;
  reg pend_valid;

  reg [`SDDF_RATE_W-1:0] next_rate;
  reg [1:0] next_osr_sel;
  reg [8:0] next_ratio;
  reg [4:0] inc_sh;
  reg [7:0] dec_max;
  wire [`SDDF_NCO_W-1:0] inc;
  wire [`SDDF_NCO_W:0] sum;
  wire [DW-1:0] ch_word;
  wire [CHANNELS-1:0] ch_en;
  wire fifo_ready;
  wire word_ready;

  // clamp the request and pick the band
  always @* begin
    next_rate = rate_req;
    if (rate_req > `SDDF_RATE_MAX) begin
      next_rate = `SDDF_RATE_MAX;
    end
    if (next_rate < `SDDF_RATE_EDGE_LO) begin
      next_osr_sel = `SDDF_OSR_256;
      next_ratio = `SDDF_RATIO_256;
    end else if (next_rate <= `SDDF_RATE_EDGE_HI) begin
      next_osr_sel = `SDDF_OSR_128;
      next_ratio = `SDDF_RATIO_128;
    end else begin
      next_osr_sel = `SDDF_OSR_64;
      next_ratio = `SDDF_RATIO_64;
    end
  end

  always @* begin
    inc_sh = `SDDF_INC_SH_256;
    dec_max = `SDDF_DEC_MAX_256;
    if (osr_sel == `SDDF_OSR_128) begin
      inc_sh = `SDDF_INC_SH_128;
      dec_max = `SDDF_DEC_MAX_128;
    end else if (osr_sel == `SDDF_OSR_64) begin
      inc_sh = `SDDF_INC_SH_64;
      dec_max = `SDDF_DEC_MAX_64;
    end
  end

  // half-period rate of the modulator clock: 2 * ratio * output rate
  assign inc = {{(`SDDF_NCO_W-`SDDF_RATE_W){1'b0}}, rate_cur} << inc_sh;
  assign sum = {1'b0, acc} + {1'b0, inc};
  assign word_ready = !pend_valid || fifo_ready;

  // modulator clock from a phase accumulator; rate changes restart the clock, counters and filters, not the fifo
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      rate_cur <= {`SDDF_RATE_W{1'b0}};
      osr_sel <= `SDDF_OSR_256;
      osr_active <= `SDDF_RATIO_256;
      acc <= {`SDDF_NCO_W{1'b0}};
      mod_clk <= 1'b0;
      mod_tick <= 1'b0;
      dec_cnt <= 8'h00;
      dec_tick <= 1'b0;
      settle_cnt <= 3'h0;
      flt_clr <= 1'b1;
    end else if (next_rate != rate_cur) begin
      rate_cur <= next_rate;
      osr_sel <= next_osr_sel;
      osr_active <= next_ratio;
      acc <= {`SDDF_NCO_W{1'b0}};
      mod_clk <= 1'b0;
      mod_tick <= 1'b0;
      dec_cnt <= 8'h00;
      dec_tick <= 1'b0;
      settle_cnt <= 3'h0;
      flt_clr <= 1'b1;
      state <= (next_rate == {`SDDF_RATE_W{1'b0}}) ? ST_IDLE : ST_SETTLE;
    end else begin
      flt_clr <= 1'b0;
      mod_tick <= 1'b0;
      dec_tick <= 1'b0;
      case (state)
        ST_IDLE: begin
          mod_clk <= 1'b0;
        end
        default: begin
          if (sum >= {1'b0, `SDDF_CLK_HZ}) begin
            acc <= sum[`SDDF_NCO_W-1:0] - `SDDF_CLK_HZ;
            mod_clk <= ~mod_clk;
            // bits are taken as the clock rises, modulators change on the fall
            if (!mod_clk) begin
              mod_tick <= 1'b1;
            end
          end else begin
            acc <= sum[`SDDF_NCO_W-1:0];
          end
          if (mod_tick) begin
            if (dec_cnt == dec_max) begin
              dec_cnt <= 8'h00;
              dec_tick <= 1'b1;
            end else begin
              dec_cnt <= dec_cnt + 8'h01;
            end
          end
          // the first words carry the filter's start-up transient
          if (state == ST_SETTLE && ch_en[0]) begin
            if (settle_cnt == `SDDF_SETTLE - 3'h1) begin
              state <= ST_RUN;
            end
            settle_cnt <= settle_cnt + 3'h1;
          end
        end
      endcase
    end
  end

  // one filter per channel
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i = i + 1) begin : g_ch
      // sinc^5 decimator: nulls at every multiple of the output rate
      sddf_sinc #(
        .ORDER(`SDDF_ORDER),
        .W(42)
      ) u_sinc (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clr(flt_clr),
        .osr_sel(osr_sel),
        .in_en(mod_tick),
        .in_bit(mod_bits[i]),
        .dec_en(dec_tick),
        .out_word(ch_word[i*`SDDF_WORD_W +: `SDDF_WORD_W]),
        .out_en(ch_en[i])
      );
    end
  endgenerate

  // holding word in front of the fifo; a full fifo costs a sample, not the stream
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pend_data <= {DW{1'b0}};
      pend_valid <= 1'b0;
      frame_strobe <= 1'b0;
      overrun <= 1'b0;
    end else begin
      frame_strobe <= 1'b0;
      overrun <= 1'b0;
      if (ch_en[0] && state == ST_RUN && !flt_clr) begin
        if (word_ready) begin
          pend_data <= ch_word;
          pend_valid <= 1'b1;
          frame_strobe <= 1'b1;
        end else begin
          overrun <= 1'b1;
        end
      end else if (fifo_ready) begin
        pend_valid <= 1'b0;
      end
    end
  end

  sddf_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_data(pend_data),
    .in_valid(pend_valid),
    .in_ready(fifo_ready),
    .out_data(smp_data),
    .out_valid(smp_valid),
    .out_ready(smp_ready)
  );

endmodule // sddf_top

// ==== verification/sddf_modulator_model.sv ====
module sddf_modulator_model (
  // modulator clock from the block
  input wire logic mod_clk,
  // full-scale level per channel, 1 is positive
  input wire logic [7:0] level,
  // bit streams
  output logic [7:0] mod_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  initial mod_bits = 8'h00;
  // a full-scale input is a constant stream; new levels only land on a falling
  // edge so a bit never moves while the block may sample it
  always @(negedge mod_clk) begin
    mod_bits <= level;
  end
endmodule // sddf_modulator_model

// ==== verification/sddf_top_assertions.sv ====
module sddf_top_assertions #(
  parameter CHANNELS = 8
) (
  // clock and reset
  input logic ref_clk,
  input logic rstn,
  // rate and modulator clock
  input logic [17:0] rate_req,
  input logic mod_clk,
  // sample stream
  input logic [CHANNELS*24-1:0] smp_data,
  input logic smp_valid,
  input logic smp_ready,
  // status
  input logic frame_strobe,
  input logic overrun,
  input logic [8:0] osr_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // a rate takes one edge to land, so only a rate already held is judged
  a_band_low: assert property (
    rate_req != 0 && rate_req < 18'h0c800 && $stable(rate_req) |-> osr_active == 9'h100)
    else $error("ratio not 256");
  a_band_mid: assert property (
    rate_req >= 18'h0c800 && rate_req <= 18'h19000 && $stable(rate_req)
    |-> osr_active == 9'h080)
    else $error("ratio not 128");
  a_band_high: assert property (
    rate_req > 18'h19000 && $stable(rate_req) |-> osr_active == 9'h040)
    else $error("ratio not 64");
  a_idle_clock: assert property (
    rate_req == 0 && $past(rate_req) == 0 |-> !mod_clk)
    else $error("modulator clock runs at rate 0");
  a_clock_half: assert property (
    rate_req >= 18'h0c800 && $rose(mod_clk) |-> ##[1:17] !mod_clk)
    else $error("modulator clock high too long");
  a_strobe_single: assert property (
    frame_strobe |=> !frame_strobe)
    else $error("frame strobe longer than one cycle");
  a_frame_out: assert property (
    frame_strobe && smp_ready && !smp_valid |-> ##[1:3] smp_valid)
    else $error("sample set did not reach the stream");
  a_stream_hold: assert property (
    smp_valid && !smp_ready |=> smp_valid && $stable(smp_data))
    else $error("stream word changed before taken");
  a_overrun_single: assert property (
    overrun |=> !overrun)
    else $error("overrun longer than one cycle");
  a_overrun_full: assert property (
    overrun |-> smp_valid && !$past(smp_ready))
    else $error("overrun while buffer drains");
endmodule // sddf_top_assertions

// ==== verification/sddf_top_test.sv ====
module sddf_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CHANNELS = 8;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [17:0] rate_req = 18'h0;
  logic smp_ready = 1'b1;
  logic [7:0] level = 8'h00;
  logic [7:0] mod_bits;
  logic mod_clk;
  logic frame_strobe;
  logic overrun;
  logic smp_valid;
  logic [191:0] smp_data;
  logic [8:0] osr_active;
  logic [191:0] exp_q[$];
  integer seed = 32'hca32782f;
  int err_total = 0;
  int compares = 0;
  int got = 0;
  int ovr_cnt = 0;
  int n;
  // modulator clock rises counted between two sample sets
  logic [8:0] exp_ratio = 9'h100;
  logic [17:0] rate_seen = 18'h0;
  logic mod_prev = 1'b0;
  bit strobe_seen = 1'b0;
  int rises = 0;

  always #2.5 ref_clk = ~ref_clk;

  sddf_top u_sddf_top (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .rate_req(rate_req),
    .mod_clk(mod_clk),
    .mod_bits(mod_bits),
    .smp_data(smp_data),
    .smp_valid(smp_valid),
    .smp_ready(smp_ready),
    .frame_strobe(frame_strobe),
    .overrun(overrun),
    .osr_active(osr_active)
  );

  sddf_modulator_model u_sddf_modulator_model (
    .mod_clk(mod_clk),
    .level(level),
    .mod_bits(mod_bits)
  );

  task automatic cmp_word(input string what, input logic [191:0] exp, input logic [191:0] obs);
    compares++;
    if (obs !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, obs);
    end
  endtask

  task automatic cmp_num(input string what, input logic [31:0] exp, input logic [31:0] obs);
    compares++;
    if (obs !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, obs);
    end
  endtask

  task automatic stop_test;
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // full scale saturates to the end codes instead of wrapping
  function automatic logic [191:0] full_scale(input logic [7:0] lv);
    for (int i = 0; i < 8; i++) begin
      full_scale[24*i +: 24] = lv[i] ? 24'h7fffff : 24'h800000;
    end
  endfunction

  task automatic wait_drain(input int limit);
    int k = 0;
    while (exp_q.size() != 0 && k < limit) begin
      @(posedge ref_clk);
      k++;
    end
    if (exp_q.size() != 0) begin
      err_total++;
      $display("MISMATCH pending_words expected 0 seen %0d", exp_q.size());
      stop_test();
    end
  endtask

  // a rate change restarts the filters; early words are discarded by the block
  task automatic run_phase(input logic [17:0] rate, input logic [8:0] osr, input int words);
    @(posedge ref_clk);
    #1;
    rate_req = rate;
    exp_ratio = osr;
    level = 8'($random(seed));
    repeat (10) @(posedge ref_clk);
    #1;
    cmp_num("osr_active", {23'h0, osr}, {23'h0, osr_active});
    repeat (words) exp_q.push_back(full_scale(level));
    wait_drain(40000);
  endtask

  always @(posedge ref_clk) begin
    if (overrun === 1'b1) begin
      ovr_cnt++;
    end
    if (mod_clk === 1'b1 && !mod_prev) begin
      rises++;
    end
    mod_prev = (mod_clk === 1'b1);
    // a dropped set or a restart breaks the count, so the next pair starts over
    if (frame_strobe === 1'b1) begin
      if (strobe_seen) begin
        cmp_num("ratio", {23'h0, exp_ratio}, rises);
      end
      strobe_seen = 1'b1;
      rises = 0;
    end else if (overrun === 1'b1) begin
      strobe_seen = 1'b0;
    end
    if (rate_req !== rate_seen) begin
      strobe_seen = 1'b0;
      rate_seen = rate_req;
    end
    if (rstn && smp_valid === 1'b1 && smp_ready) begin
      got++;
      if (exp_q.size() != 0) begin
        cmp_word("smp_data", exp_q.pop_front(), smp_data);
      end
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    run_phase(18'h0c7ff, 9'h100, 2);
    run_phase(18'h0c800, 9'h080, 0);
    run_phase(18'h19000, 9'h080, 2);
    run_phase(18'h19001, 9'h040, 0);
    run_phase(18'h3d090, 9'h040, 2);
    // stall the stream until a set is dropped, then drain everything held
    @(posedge ref_clk);
    #1;
    smp_ready = 1'b0;
    n = 0;
    while (ovr_cnt == 0 && n < 30000) begin
      @(posedge ref_clk);
      n++;
    end
    #1;
    cmp_num("overrun", 32'h1, ovr_cnt);
    repeat (18) exp_q.push_back(full_scale(level));
    got = 0;
    smp_ready = 1'b1;
    repeat (40) @(posedge ref_clk);
    #1;
    cmp_num("drained_words", 32'h12, got);
    cmp_num("smp_valid", 32'h0, {31'h0, smp_valid});
    wait_drain(2);
    rate_req = 18'h0;
    repeat (200) @(posedge ref_clk);
    stop_test();
  end
endmodule // sddf_top_test

bind sddf_top sddf_top_assertions #(.CHANNELS(CHANNELS)) u_sddf_top_assertions (
  .ref_clk(ref_clk),
  .rstn(rstn),
  .rate_req(rate_req),
  .mod_clk(mod_clk),
  .smp_data(smp_data),
  .smp_valid(smp_valid),
  .smp_ready(smp_ready),
  .frame_strobe(frame_strobe),
  .overrun(overrun),
  .osr_active(osr_active)
);
